// ### core/adc_port_pkg.sv
// Purpose: shared constants for the serial converter readout port
// Assumes: core clock at 200 MHz; shift clock and select arrive as pins
// Notes: times are kept in their own unit, cycle counts derive from them
`default_nettype none

package adc_port_pkg;

  // converter word
  localparam int RESULT_W = 12;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 4'hb;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [RESULT_W-1:0] TRIAL_MSB = 12'h800;
  localparam logic NULL_BIT = 1'b0;
  localparam logic FILL_BIT = 1'b0;

  // core clock
  localparam real CLK_PERIOD_NS = 5.0;

  // least select-high time between transfers
  localparam real SELECT_HIGH_TIME_US = 5.0;
  // least select-low to clock-high setup
  localparam real SELECT_TO_CLOCK_SETUP_NS = 100.0;
  // highest shift clock rate
  localparam real SCLK_MAX_FREQ_KHZ = 500.0;

  // monitor counter width, enough for the longest count below
  localparam int MON_W = 11;
  localparam logic [MON_W-1:0] SELECT_HIGH_CYC =
    MON_W'(int'($ceil(SELECT_HIGH_TIME_US * 1000.0 / CLK_PERIOD_NS)));
  localparam logic [MON_W-1:0] SELECT_SETUP_CYC =
    MON_W'(int'($ceil(SELECT_TO_CLOCK_SETUP_NS / CLK_PERIOD_NS)));
  localparam logic [MON_W-1:0] SCLK_MIN_PERIOD_CYC =
    MON_W'(int'($ceil(1.0e6 / SCLK_MAX_FREQ_KHZ / CLK_PERIOD_NS)));

  // transfer sequencer states
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_ARMED   = 6'b000010,
    ST_SAMPLE  = 6'b000100,
    ST_CONVERT = 6'b001000,
    ST_REPLAY  = 6'b010000,
    ST_DONE    = 6'b100000
  } xfer_state_t;

endpackage : adc_port_pkg

`default_nettype wire

// ### core/sar_engine.sv
// Purpose: successive-approximation register, one bit decision per step
// Assumes: comparator level already synchronised by the caller
// Notes: comp_i high means the held input is at or above the trial code
`default_nettype none

module sar_engine (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // control
  input wire logic clear_i,
  input wire logic start_i,
  input wire logic decide_i,
  input wire logic comp_i,
  // results
  output logic [adc_port_pkg::RESULT_W-1:0] trial_o,
  output logic [adc_port_pkg::RESULT_W-1:0] result_o
);
  import adc_port_pkg::*;

  logic [RESULT_W-1:0] code_q;
  logic [RESULT_W-1:0] mask_q;
  logic [RESULT_W-1:0] res_q;

  // trial code drives the capacitor dac; mask marks the bit under test
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      code_q <= RESULT_RST;
      mask_q <= RESULT_RST;
    end else if (clear_i) begin
      code_q <= RESULT_RST;
      mask_q <= RESULT_RST;
    end else if (start_i) begin
      code_q <= TRIAL_MSB;
      mask_q <= TRIAL_MSB;
    end else if (decide_i && (mask_q != RESULT_RST)) begin
      code_q <= (comp_i ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

  // settled word, built bit by bit as decisions land
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_q <= RESULT_RST;
    end else if (clear_i || start_i) begin
      res_q <= RESULT_RST;
    end else if (decide_i && (mask_q != RESULT_RST)) begin
      res_q <= comp_i ? (res_q | mask_q) : res_q;
    end
  end

  assign trial_o = code_q;
  assign result_o = res_q;

endmodule : sar_engine

`default_nettype wire

// ### core/serial_adc_readout_port.sv
// Purpose: control, timing and three-wire serial output of a 12-bit converter
// Assumes: select and shift clock come from the host as pins, comparator from the analog core
// Notes: every pin input is synchronised; edges are seen two to three core cycles late
`default_nettype none

module serial_adc_readout_port (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // host serial link
  input wire logic select_n_i,
  input wire logic sclk_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  // analog core
  input wire logic comp_i,
  output logic [adc_port_pkg::RESULT_W-1:0] dac_code_o,
  output logic sample_o,
  output logic cap_to_neg_o,
  // status
  output logic converting_o,
  output logic short_gap_o,
  output logic short_setup_o,
  output logic fast_clk_o
);
  import adc_port_pkg::*;

  function automatic logic rise(input logic now, input logic old);
    rise = now & ~old;
  endfunction : rise

  function automatic logic fall(input logic now, input logic old);
    fall = ~now & old;
  endfunction : fall

  // synchronisers; the first stage feeds only the second
  logic sel_s1_q;
  logic sel_s2_q;
  logic sel_s3_q;
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic comp_s1_q;
  logic comp_s2_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
    end else begin
      sel_s1_q <= select_n_i;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
    end else begin
      sclk_s1_q <= sclk_i;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_i;
      comp_s2_q <= comp_s1_q;
    end
  end

  logic sel_active;
  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;

  assign sel_active = ~sel_s2_q;
  assign sel_fall = fall(sel_s2_q, sel_s3_q);
  assign sclk_rise = rise(sclk_s2_q, sclk_s3_q);
  assign sclk_fall = fall(sclk_s2_q, sclk_s3_q);

  // transfer sequencer
  xfer_state_t state_q;
  xfer_state_t state_d;
  logic [BIT_CNT_W-1:0] bit_q;
  logic sar_clear;
  logic sar_start;
  logic sar_decide;
  logic [RESULT_W-1:0] result;

  always_comb begin
    state_d = state_q;
    sar_clear = 1'b0;
    sar_start = 1'b0;
    sar_decide = 1'b0;
    if (!sel_active) begin
      state_d = ST_IDLE;
      sar_clear = 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_ARMED;
        end
        ST_ARMED: begin
          if (sclk_rise) begin
            state_d = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (sclk_fall) begin
            state_d = ST_CONVERT;
            sar_start = 1'b1;
          end
        end
        ST_CONVERT: begin
          if (sclk_fall) begin
            sar_decide = 1'b1;
            if (bit_q == LAST_BIT_IDX) begin
              state_d = ST_REPLAY;
            end
          end
        end
        ST_REPLAY: begin
          if (sclk_fall && (bit_q == LAST_BIT_IDX)) begin
            state_d = ST_DONE;
          end
        end
        ST_DONE: begin
          state_d = ST_DONE;
        end
        default: begin
          state_d = ST_IDLE;
          sar_clear = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit counter: counts decisions, then replayed bits
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_q <= '0;
    end else if (sar_clear || sar_start) begin
      bit_q <= '0;
    end else if (sclk_fall && (state_q == ST_CONVERT || state_q == ST_REPLAY)) begin
      bit_q <= (bit_q == LAST_BIT_IDX) ? '0 : bit_q + 4'h1;
    end
  end

  // only the comparator and the select/clock pins steer the converter
  sar_engine u_sar (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clear_i(sar_clear),
    .start_i(sar_start),
    .decide_i(sar_decide),
    .comp_i(comp_s2_q),
    .trial_o(dac_code_o),
    .result_o(result)
  );

  // serial output data; changes on shift clock falling edges, and returns to the null bit when select rises
  logic dout_q;
  logic drive_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_q <= NULL_BIT;
    end else if (!sel_active) begin
      dout_q <= NULL_BIT;
    end else if (sclk_fall) begin
      case (state_q)
        ST_SAMPLE: begin
          dout_q <= NULL_BIT;
        end
        ST_CONVERT: begin
          // bit just decided goes straight out, so MSB leads
          dout_q <= comp_s2_q;
        end
        ST_REPLAY: begin
          // the word finished in this same transfer, LSB first
          dout_q <= result[bit_q];
        end
        default: begin
          dout_q <= FILL_BIT;
        end
      endcase
    end
  end

  // the last MSB-first bit is also the first replay bit source; replay reads result,
  // so the LSB is sent twice only as part of two full words, as a host expects
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_q <= 1'b0;
    end else if (!sel_active) begin
      drive_q <= 1'b0;
    end else if (state_q == ST_ARMED && sclk_rise) begin
      drive_q <= 1'b1;
    end
  end

  assign dout_o = dout_q;
  assign dout_oe_n_o = ~drive_q;

  // sample and hold control: tracking from select rise until the hold edge
  logic sample_q;
  logic neg_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_q <= 1'b1;
      neg_q <= 1'b0;
    end else if (!sel_active) begin
      sample_q <= 1'b1;
      neg_q <= 1'b0;
    end else if (sar_start) begin
      sample_q <= 1'b0;
      neg_q <= 1'b1;
    end
  end

  assign sample_o = sample_q;
  assign cap_to_neg_o = neg_q;
  assign converting_o = (state_q == ST_CONVERT);

  // host timing monitors; they report, they never alter the transfer
  logic [MON_W-1:0] gap_cnt_q;
  logic [MON_W-1:0] setup_cnt_q;
  logic [MON_W-1:0] per_cnt_q;
  logic seen_rise_q;
  logic short_gap_q;
  logic short_setup_q;
  logic fast_clk_q;

  // select-high time, saturating so a long idle never wraps
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_cnt_q <= SELECT_HIGH_CYC;
    end else if (sel_active) begin
      gap_cnt_q <= '0;
    end else if (gap_cnt_q != SELECT_HIGH_CYC) begin
      gap_cnt_q <= gap_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      short_gap_q <= 1'b0;
    end else if (sel_fall) begin
      short_gap_q <= (gap_cnt_q < SELECT_HIGH_CYC);
    end
  end

  // select-low to first clock rise
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup_cnt_q <= '0;
    end else if (!sel_active) begin
      setup_cnt_q <= '0;
    end else if (setup_cnt_q != SELECT_SETUP_CYC) begin
      setup_cnt_q <= setup_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      short_setup_q <= 1'b0;
    end else if (sel_fall) begin
      short_setup_q <= 1'b0;
    end else if (state_q == ST_ARMED && sclk_rise && setup_cnt_q < SELECT_SETUP_CYC) begin
      short_setup_q <= 1'b1;
    end
  end

  // shift clock period between rising edges
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_cnt_q <= '0;
      seen_rise_q <= 1'b0;
    end else if (!sel_active) begin
      per_cnt_q <= '0;
      seen_rise_q <= 1'b0;
    end else if (sclk_rise) begin
      per_cnt_q <= 11'h001; // the rise cycle counts, so an exact legal period passes
      seen_rise_q <= 1'b1;
    end else if (per_cnt_q != SCLK_MIN_PERIOD_CYC) begin
      per_cnt_q <= per_cnt_q + 11'h001;
    end
  end

  // sticky per transfer; a new select fall clears it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_clk_q <= 1'b0;
    end else if (sclk_rise && seen_rise_q && per_cnt_q < SCLK_MIN_PERIOD_CYC) begin
      fast_clk_q <= 1'b1;
    end else if (sel_fall) begin
      fast_clk_q <= 1'b0;
    end
  end

  assign short_gap_o = short_gap_q;
  assign short_setup_o = short_setup_q;
  assign fast_clk_o = fast_clk_q;

endmodule : serial_adc_readout_port

`default_nettype wire

// ### tb/adc_host_model.sv
// Purpose: host side of the three-wire link, makes select and shift clock
// Assumes: all timing counted in core clock cycles
// Notes: shift clock stands low outside frames
`default_nettype none

module adc_host_model (
  // core clock
  input wire logic ref_clk_i,
  // link
  input wire logic dout_line_i,
  output logic select_n_o,
  output logic sclk_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // null bit, msb-first word, lsb-first word in arrival order
  logic [24:0] bits_q;

  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    bits_q = 25'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // half sets the clock rate; 200 cycles is the fastest legal rate
  task automatic xfer(input int gap, input int setup, input int half, input int nclk);
    tick(gap);
    select_n_o = 1'b0;
    tick(setup);
    for (int i = 1; i <= nclk; i++) begin
      // capture at the rising edge, before it is raised
      if (i >= 2 && i <= 26)
        bits_q[26 - i] = dout_line_i;
      sclk_o = 1'b1;
      tick(half);
      sclk_o = 1'b0;
      tick(half);
    end
  endtask : xfer

  task automatic finish;
    select_n_o = 1'b1;
  endtask : finish

endmodule : adc_host_model

`default_nettype wire

// ### tb/serial_adc_readout_port_asserts.sv
// Purpose: pin-level assertions for the serial converter readout port
// Assumes: host drives pins just after core clock edges
// Notes: pins pass synchronisers, so effects land three to six core cycles late
`default_nettype none

module serial_adc_readout_port_asserts (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // host link
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_n_o,
  // analog core
  input wire logic comp_i,
  input wire logic [adc_port_pkg::RESULT_W-1:0] dac_code_o,
  input wire logic sample_o,
  input wire logic cap_to_neg_o,
  // status
  input wire logic converting_o,
  input wire logic short_gap_o,
  input wire logic short_setup_o,
  input wire logic fast_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_port_pkg::*;

  logic sclk_q;
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;

  // clock edges seen in the current frame, saturating so long frames cannot wrap
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk_i;
      if (select_n_i) begin
        rise_cnt <= 5'h00;
        fall_cnt <= 5'h00;
      end else begin
        if (sclk_i && !sclk_q && rise_cnt != 5'h1f)
          rise_cnt <= rise_cnt + 5'h01;
        if (!sclk_i && sclk_q && fall_cnt != 5'h1f)
          fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_oe_release;
    $rose(select_n_i) |-> ##[2:6] dout_oe_n_o [*4];
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("output still driven after select rose");

  property p_oe_before_clk;
    !select_n_i && rise_cnt == 5'h00 |-> dout_oe_n_o;
  endproperty
  a_oe_before_clk: assert property (p_oe_before_clk) else $error("output driven before first clock");

  property p_oe_on;
    $rose(sclk_i) && !select_n_i && rise_cnt == 5'h00 |-> ##[3:6] !dout_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled by first clock");

  property p_dout_still;
    (sclk_i && !select_n_i) [*3] |-> dout_oe_n_o || $stable(dout_o);
  endproperty
  a_dout_still: assert property (p_dout_still) else $error("data moved while clock high");

  property p_track;
    (fall_cnt == 5'h00) [*6] |-> sample_o && !cap_to_neg_o;
  endproperty
  a_track: assert property (p_track) else $error("not tracking before first fall");

  property p_hold;
    $fell(sclk_i) && !select_n_i && fall_cnt == 5'h00 |-> ##[2:6] (!sample_o && cap_to_neg_o && converting_o);
  endproperty
  a_hold: assert property (p_hold) else $error("no hold at first fall");

  property p_msb_trial;
    $fell(sclk_i) && !select_n_i && fall_cnt == 5'h00 |-> ##6 dac_code_o == TRIAL_MSB;
  endproperty
  a_msb_trial: assert property (p_msb_trial) else $error("first trial code wrong");

  property p_conv_on;
    $fell(sclk_i) && !select_n_i && fall_cnt == 5'h0b |-> ##6 converting_o;
  endproperty
  a_conv_on: assert property (p_conv_on) else $error("conversion ended early");

  property p_conv_off;
    $fell(sclk_i) && !select_n_i && fall_cnt == 5'h0c |-> ##6 !converting_o;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("conversion ran past twelve clocks");

endmodule : serial_adc_readout_port_asserts

bind serial_adc_readout_port serial_adc_readout_port_asserts u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .select_n_i(select_n_i), .sclk_i(sclk_i),
  .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .comp_i(comp_i), .dac_code_o(dac_code_o),
  .sample_o(sample_o), .cap_to_neg_o(cap_to_neg_o), .converting_o(converting_o),
  .short_gap_o(short_gap_o), .short_setup_o(short_setup_o), .fast_clk_o(fast_clk_o)
);

`default_nettype wire

// ### tb/serial_adc_readout_port_test.sv
// Purpose: self-checking bench for the serial converter readout port
// Assumes: a behavioural sample-and-hold and comparator stand in for the analog core
// Notes: most frames run the shift clock fast to keep the run short
`default_nettype none

module serial_adc_readout_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_port_pkg::*;

  logic ref_clk_i, nrst_i, comp_i, dout_o, dout_oe_n_o;
  logic select_n_i, sclk_i, sample_o, cap_to_neg_o, converting_o;
  logic short_gap_o, short_setup_o, fast_clk_o;
  logic [11:0] dac_code_o, vin, held_v;
  int errors, num_checks;
  wire dout_line = dout_oe_n_o ? 1'bz : dout_o;

  serial_adc_readout_port dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .select_n_i(select_n_i), .sclk_i(sclk_i),
    .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .comp_i(comp_i), .dac_code_o(dac_code_o),
    .sample_o(sample_o), .cap_to_neg_o(cap_to_neg_o), .converting_o(converting_o),
    .short_gap_o(short_gap_o), .short_setup_o(short_setup_o), .fast_clk_o(fast_clk_o)
  );

  adc_host_model u_host (.ref_clk_i(ref_clk_i), .dout_line_i(dout_line), .select_n_o(select_n_i), .sclk_o(sclk_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // the held copy only follows the input while the design tracks
  always @(posedge ref_clk_i) begin
    if (sample_o === 1'b1)
      held_v <= vin;
    comp_i <= #1 (held_v >= dac_code_o);
  end

  function automatic logic [11:0] rev12(input logic [11:0] v);
    for (int i = 0; i < 12; i++)
      rev12[i] = v[11 - i];
  endfunction : rev12

  task automatic check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic frame(input logic [11:0] v, input int gap, input int setup, input int half, input int nclk);
    vin = v;
    u_host.xfer(gap, setup, half, nclk);
    check_bit("null_bit", NULL_BIT, u_host.bits_q[24]);
    check_word("msb_word", v, u_host.bits_q[23:12]);
    if (nclk >= 26)
      check_word("lsb_word", rev12(v), u_host.bits_q[11:0]);
  endtask : frame

  initial begin
    logic [11:0] codes [6];
    errors = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    vin = 12'h000;
    held_v = 12'h000;
    comp_i = 1'b0;
    void'($urandom(32'h0d86));
    codes = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h000, 12'h000};
    codes[4] = 12'($urandom);
    codes[5] = 12'($urandom);
    repeat (16) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    check_bit("oe_n_reset", 1'b1, dout_oe_n_o);
    frame(12'ha5c, 1100, 40, 200, 26);
    check_bit("fast_clk_legal", 1'b0, fast_clk_o);
    check_bit("short_gap_legal", 1'b0, short_gap_o);
    check_bit("short_setup_legal", 1'b0, short_setup_o);
    u_host.finish();
    foreach (codes[i]) begin
      frame(codes[i], 1100, 40, 25, 26);
      check_bit("fast_clk", 1'b1, fast_clk_o);
      u_host.finish();
    end
    frame(codes[4] ^ 12'h555, 100, 40, 25, 26);
    check_bit("short_gap", 1'b1, short_gap_o);
    u_host.finish();
    // first clock too soon after select; only the flag is judged
    u_host.xfer(1100, 10, 25, 26);
    check_bit("short_setup", 1'b1, short_setup_o);
    u_host.finish();
    // abort mid conversion, then a clean frame must carry fresh data
    vin = 12'h123;
    u_host.xfer(1100, 40, 25, 6);
    u_host.finish();
    repeat (8) @(posedge ref_clk_i);
    #1;
    check_bit("oe_n_abort", 1'b1, dout_oe_n_o);
    check_bit("sample_abort", 1'b1, sample_o);
    check_bit("converting_abort", 1'b0, converting_o);
    frame(12'h456, 1100, 40, 25, 26);
    u_host.finish();
    // input moves during conversion; the held value must win
    fork
      frame(12'h3c3, 1100, 40, 25, 26);
      begin
        repeat (1500) @(posedge ref_clk_i);
        #1;
        vin = 12'hc3c;
      end
    join
    u_host.finish();
    frame(12'h9b6, 1100, 40, 25, 14);
    u_host.finish();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up();
  end

endmodule : serial_adc_readout_port_test

`default_nettype wire
